/* design/css_pkg.sv */
// shared constants and types for the command source selector
package css_pkg;

  // register bus geometry, command field widths and input counts
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned RUN_W  = 2;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned NUM_LOCAL_IN = 4;
  localparam int unsigned NUM_PRESET   = 3;

  // register byte addresses
  localparam logic [7:0] ADDR_LINK_MODE  = 8'h00;
  localparam logic [7:0] ADDR_FBUS_MODE  = 8'h04;
  localparam logic [7:0] ADDR_FSEL_ONE   = 8'h08;
  localparam logic [7:0] ADDR_FSEL_TWO   = 8'h0C;
  localparam logic [7:0] ADDR_RUN_SEL    = 8'h10;
  localparam logic [7:0] ADDR_PRESET_1   = 8'h14;
  localparam logic [7:0] ADDR_PRESET_2   = 8'h18;
  localparam logic [7:0] ADDR_PRESET_3   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS     = 8'h20;
  localparam logic [7:0] ADDR_FREQ_OUT   = 8'h24;

  // reset values
  localparam logic [3:0]  RST_MODE    = 4'h0;
  localparam logic [1:0]  RST_SEL     = 2'h0;
  localparam logic [0:0]  RST_RUN_SEL = 1'h0;
  localparam logic [15:0] RST_FREQ    = 16'h0000;
  localparam logic [1:0]  RST_RUN     = 2'h0;

  // highest legal mode values
  localparam logic [3:0] LINK_MODE_MAX = 4'h8;
  localparam logic [3:0] FBUS_MODE_MAX = 4'h3;

  // status register field positions
  localparam int unsigned ST_FREQ_SRC_LSB = 0;
  localparam int unsigned ST_RUN_SRC_LSB  = 2;
  localparam int unsigned ST_FAULT_BIT    = 4;

  // run source selector codes
  localparam logic [0:0] RUN_SEL_KEYPAD   = 1'h0;
  localparam logic [0:0] RUN_SEL_TERMINAL = 1'h1;

  // where a command is taken from
  typedef enum logic [1:0] {
    CSS_SRC_LOCAL,
    CSS_SRC_STD_LINK,
    CSS_SRC_CARD_LINK,
    CSS_SRC_FIELDBUS
  } css_src_e;

  // one command frame from a remote party
  typedef struct packed {
    logic              valid;
    logic [FREQ_W-1:0] freq;
    logic [RUN_W-1:0]  run;
  } css_cmd_s;

  // frame on the shared keypad / standard link port
  typedef struct packed {
    logic              valid;
    logic              from_link;
    logic [FREQ_W-1:0] freq;
    logic [RUN_W-1:0]  run;
  } css_port_s;

endpackage : css_pkg

/* design/css_src_decode.sv */
// decode of the two mode settings into command sources
`timescale 1ns/1ps
`default_nettype none
module css_src_decode (
  // mode settings
  input  wire logic [3:0]       link_mode_setting,
  input  wire logic [3:0]       fieldbus_mode_setting,
  // decoded sources
  output var css_pkg::css_src_e freq_src,
  output var css_pkg::css_src_e run_src,
  output logic                  mode_ok
);

  css_pkg::css_src_e link_freq;
  css_pkg::css_src_e link_run;

  // link mode table for both commands
  always_comb begin
    link_freq = css_pkg::CSS_SRC_LOCAL;
    link_run  = css_pkg::CSS_SRC_LOCAL;
    unique case (link_mode_setting)
      4'h0: begin link_freq = css_pkg::CSS_SRC_LOCAL;     link_run = css_pkg::CSS_SRC_LOCAL;     end
      4'h1: begin link_freq = css_pkg::CSS_SRC_STD_LINK;  link_run = css_pkg::CSS_SRC_LOCAL;     end
      4'h2: begin link_freq = css_pkg::CSS_SRC_LOCAL;     link_run = css_pkg::CSS_SRC_STD_LINK;  end
      4'h3: begin link_freq = css_pkg::CSS_SRC_STD_LINK;  link_run = css_pkg::CSS_SRC_STD_LINK;  end
      4'h4: begin link_freq = css_pkg::CSS_SRC_CARD_LINK; link_run = css_pkg::CSS_SRC_LOCAL;     end
      4'h5: begin link_freq = css_pkg::CSS_SRC_CARD_LINK; link_run = css_pkg::CSS_SRC_STD_LINK;  end
      4'h6: begin link_freq = css_pkg::CSS_SRC_LOCAL;     link_run = css_pkg::CSS_SRC_CARD_LINK; end
      4'h7: begin link_freq = css_pkg::CSS_SRC_STD_LINK;  link_run = css_pkg::CSS_SRC_CARD_LINK; end
      4'h8: begin link_freq = css_pkg::CSS_SRC_CARD_LINK; link_run = css_pkg::CSS_SRC_CARD_LINK; end
      default: begin link_freq = css_pkg::CSS_SRC_LOCAL;  link_run = css_pkg::CSS_SRC_LOCAL;     end
    endcase
  end

  // field bus override; link mode ignored for a command on the field bus
  always_comb begin
    freq_src = fieldbus_mode_setting[0] ? css_pkg::CSS_SRC_FIELDBUS : link_freq;
    run_src  = fieldbus_mode_setting[1] ? css_pkg::CSS_SRC_FIELDBUS : link_run;
    // reserved values flagged; a link mode only matters where a command still follows it
    mode_ok  = (fieldbus_mode_setting <= css_pkg::FBUS_MODE_MAX) &&
               ((fieldbus_mode_setting == css_pkg::FBUS_MODE_MAX) ||
                (link_mode_setting <= css_pkg::LINK_MODE_MAX));
  end

endmodule : css_src_decode
`default_nettype wire

/* design/css_selector.sv */
// command source selector: registers, link capture and command steering
`timescale 1ns/1ps
`default_nettype none
module css_selector (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // local frequency inputs and terminals
  input  wire logic [3:0][15:0]     local_freq_in,
  input  wire logic                 alt_sel_in,
  input  wire logic [1:0]           preset_sel_in,
  input  wire logic [1:0]           term_run_in,
  // shared keypad / standard link port
  input  wire css_pkg::css_port_s   keypad_port_in,
  // option card link and field bus
  input  wire css_pkg::css_cmd_s    card_link_in,
  input  wire css_pkg::css_cmd_s    fieldbus_in,
  // steered commands
  output logic [15:0]               freq_cmd,
  output logic [1:0]                run_cmd,
  output var css_pkg::css_src_e     freq_src,
  output var css_pkg::css_src_e     run_src
);

  // settings registers
  logic [3:0]  link_mode_setting_reg, link_mode_setting_next;
  logic [3:0]  fieldbus_mode_setting_reg, fieldbus_mode_setting_next;
  logic [1:0]  freq_setting_selector_one_reg, freq_setting_selector_one_next;
  logic [1:0]  freq_setting_selector_two_reg, freq_setting_selector_two_next;
  logic [0:0]  run_source_selector_reg, run_source_selector_next;
  logic [15:0] preset_reg [1:3];
  logic [15:0] preset_next [1:3];
  logic [31:0] rdata_reg, rdata_next;

  // captured remote commands
  logic [15:0] keypad_freq_reg, keypad_freq_next;
  logic [1:0]  keypad_run_reg, keypad_run_next;
  logic [15:0] std_freq_reg, std_freq_next;
  logic [1:0]  std_run_reg, std_run_next;
  logic [15:0] card_freq_reg, card_freq_next;
  logic [1:0]  card_run_reg, card_run_next;
  logic [15:0] fbus_freq_reg, fbus_freq_next;
  logic [1:0]  fbus_run_reg, fbus_run_next;

  // steered state
  css_pkg::css_src_e freq_src_reg, freq_src_next;
  css_pkg::css_src_e run_src_reg, run_src_next;
  logic [15:0]       freq_cmd_reg, freq_cmd_next;
  logic [1:0]        run_cmd_reg, run_cmd_next;
  logic              fault_reg, fault_next;

  // decoder outputs and local values
  css_pkg::css_src_e dec_freq_src;
  css_pkg::css_src_e dec_run_src;
  logic              dec_ok;
  logic [15:0]       local_freq;
  logic [1:0]        local_run;

  css_src_decode u_decode (
    .link_mode_setting     (link_mode_setting_reg),
    .fieldbus_mode_setting (fieldbus_mode_setting_reg),
    .freq_src              (dec_freq_src),
    .run_src               (dec_run_src),
    .mode_ok               (dec_ok)
  );

  // register writes and read data
  always_comb begin
    link_mode_setting_next         = link_mode_setting_reg;
    fieldbus_mode_setting_next     = fieldbus_mode_setting_reg;
    freq_setting_selector_one_next = freq_setting_selector_one_reg;
    freq_setting_selector_two_next = freq_setting_selector_two_reg;
    run_source_selector_next       = run_source_selector_reg;
    for (int i = 1; i <= 3; i++) begin
      preset_next[i] = preset_reg[i];
    end
    rdata_next = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        css_pkg::ADDR_LINK_MODE: link_mode_setting_next         = reg_wdata[3:0];
        css_pkg::ADDR_FBUS_MODE: fieldbus_mode_setting_next     = reg_wdata[3:0];
        css_pkg::ADDR_FSEL_ONE:  freq_setting_selector_one_next = reg_wdata[1:0];
        css_pkg::ADDR_FSEL_TWO:  freq_setting_selector_two_next = reg_wdata[1:0];
        css_pkg::ADDR_RUN_SEL:   run_source_selector_next       = reg_wdata[0:0];
        css_pkg::ADDR_PRESET_1:  preset_next[1]                 = reg_wdata[15:0];
        css_pkg::ADDR_PRESET_2:  preset_next[2]                 = reg_wdata[15:0];
        css_pkg::ADDR_PRESET_3:  preset_next[3]                 = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        css_pkg::ADDR_LINK_MODE: rdata_next[3:0]  = link_mode_setting_reg;
        css_pkg::ADDR_FBUS_MODE: rdata_next[3:0]  = fieldbus_mode_setting_reg;
        css_pkg::ADDR_FSEL_ONE:  rdata_next[1:0]  = freq_setting_selector_one_reg;
        css_pkg::ADDR_FSEL_TWO:  rdata_next[1:0]  = freq_setting_selector_two_reg;
        css_pkg::ADDR_RUN_SEL:   rdata_next[0:0]  = run_source_selector_reg;
        css_pkg::ADDR_PRESET_1:  rdata_next[15:0] = preset_reg[1];
        css_pkg::ADDR_PRESET_2:  rdata_next[15:0] = preset_reg[2];
        css_pkg::ADDR_PRESET_3:  rdata_next[15:0] = preset_reg[3];
        css_pkg::ADDR_STATUS: begin
          rdata_next[css_pkg::ST_FREQ_SRC_LSB +: 2] = freq_src_reg;
          rdata_next[css_pkg::ST_RUN_SRC_LSB +: 2]  = run_src_reg;
          rdata_next[css_pkg::ST_FAULT_BIT]         = fault_reg;
        end
        css_pkg::ADDR_FREQ_OUT: begin
          rdata_next[15:0]  = freq_cmd_reg;
          rdata_next[17:16] = run_cmd_reg;
        end
        default: rdata_next = '0; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_mode_setting_reg         <= css_pkg::RST_MODE;
      fieldbus_mode_setting_reg     <= css_pkg::RST_MODE;
      freq_setting_selector_one_reg <= css_pkg::RST_SEL;
      freq_setting_selector_two_reg <= css_pkg::RST_SEL;
      run_source_selector_reg       <= css_pkg::RST_RUN_SEL;
      for (int i = 1; i <= 3; i++) begin
        preset_reg[i] <= css_pkg::RST_FREQ;
      end
      rdata_reg <= '0;
    end else begin
      link_mode_setting_reg         <= link_mode_setting_next;
      fieldbus_mode_setting_reg     <= fieldbus_mode_setting_next;
      freq_setting_selector_one_reg <= freq_setting_selector_one_next;
      freq_setting_selector_two_reg <= freq_setting_selector_two_next;
      run_source_selector_reg       <= run_source_selector_next;
      for (int i = 1; i <= 3; i++) begin
        preset_reg[i] <= preset_next[i];
      end
      rdata_reg <= rdata_next;
    end
  end

  // capture of the latest frame from each remote party
  always_comb begin
    keypad_freq_next = keypad_freq_reg;
    keypad_run_next  = keypad_run_reg;
    std_freq_next    = std_freq_reg;
    std_run_next     = std_run_reg;
    card_freq_next   = card_link_in.valid ? card_link_in.freq : card_freq_reg;
    card_run_next    = card_link_in.valid ? card_link_in.run : card_run_reg;
    fbus_freq_next   = fieldbus_in.valid ? fieldbus_in.freq : fbus_freq_reg;
    fbus_run_next    = fieldbus_in.valid ? fieldbus_in.run : fbus_run_reg;
    // one port carries both keypad and standard link frames
    if (keypad_port_in.valid && keypad_port_in.from_link) begin
      std_freq_next = keypad_port_in.freq;
      std_run_next  = keypad_port_in.run;
    end else if (keypad_port_in.valid) begin
      keypad_freq_next = keypad_port_in.freq;
      keypad_run_next  = keypad_port_in.run;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keypad_freq_reg <= css_pkg::RST_FREQ;
      keypad_run_reg  <= css_pkg::RST_RUN;
      std_freq_reg    <= css_pkg::RST_FREQ;
      std_run_reg     <= css_pkg::RST_RUN;
      card_freq_reg   <= css_pkg::RST_FREQ;
      card_run_reg    <= css_pkg::RST_RUN;
      fbus_freq_reg   <= css_pkg::RST_FREQ;
      fbus_run_reg    <= css_pkg::RST_RUN;
    end else begin
      keypad_freq_reg <= keypad_freq_next;
      keypad_run_reg  <= keypad_run_next;
      std_freq_reg    <= std_freq_next;
      std_run_reg     <= std_run_next;
      card_freq_reg   <= card_freq_next;
      card_run_reg    <= card_run_next;
      fbus_freq_reg   <= fbus_freq_next;
      fbus_run_reg    <= fbus_run_next;
    end
  end

  // local values: preset wins over selectors, alt input picks selector two
  always_comb begin
    if (preset_sel_in != 2'h0) begin
      local_freq = preset_reg[preset_sel_in];
    end else if (alt_sel_in) begin
      local_freq = local_freq_in[freq_setting_selector_two_reg];
    end else begin
      local_freq = local_freq_in[freq_setting_selector_one_reg];
    end
    local_run = (run_source_selector_reg == css_pkg::RUN_SEL_TERMINAL) ?
                term_run_in : keypad_run_reg;
  end

  // source selection held while mode_ok flags a reserved setting, then steering
  always_comb begin
    freq_src_next = dec_ok ? dec_freq_src : freq_src_reg;
    run_src_next  = dec_ok ? dec_run_src : run_src_reg;
    fault_next    = !dec_ok;
    unique case (freq_src_next)
      css_pkg::CSS_SRC_LOCAL:     freq_cmd_next = local_freq;
      css_pkg::CSS_SRC_STD_LINK:  freq_cmd_next = std_freq_reg;
      css_pkg::CSS_SRC_CARD_LINK: freq_cmd_next = card_freq_reg;
      css_pkg::CSS_SRC_FIELDBUS:  freq_cmd_next = fbus_freq_reg;
    endcase
    unique case (run_src_next)
      css_pkg::CSS_SRC_LOCAL:     run_cmd_next = local_run;
      css_pkg::CSS_SRC_STD_LINK:  run_cmd_next = std_run_reg;
      css_pkg::CSS_SRC_CARD_LINK: run_cmd_next = card_run_reg;
      css_pkg::CSS_SRC_FIELDBUS:  run_cmd_next = fbus_run_reg;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freq_src_reg <= css_pkg::CSS_SRC_LOCAL;
      run_src_reg  <= css_pkg::CSS_SRC_LOCAL;
      freq_cmd_reg <= css_pkg::RST_FREQ;
      run_cmd_reg  <= css_pkg::RST_RUN;
      fault_reg    <= 1'b0;
    end else begin
      freq_src_reg <= freq_src_next;
      run_src_reg  <= run_src_next;
      freq_cmd_reg <= freq_cmd_next;
      run_cmd_reg  <= run_cmd_next;
      fault_reg    <= fault_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_reg;
  assign freq_cmd  = freq_cmd_reg;
  assign run_cmd   = run_cmd_reg;
  assign freq_src  = freq_src_reg;
  assign run_src   = run_src_reg;

endmodule : css_selector
`default_nettype wire

/* tb/css_selector_assertions.sv */
// assertion checker for the command source selector
`timescale 1ns/1ps
`default_nettype none
module css_selector_assertions (
  // clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // register port
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  // remote frames
  input wire css_pkg::css_cmd_s card_link_in,
  input wire css_pkg::css_cmd_s fieldbus_in,
  // steered commands
  input wire logic [15:0]       freq_cmd,
  input wire logic [1:0]        run_cmd,
  input wire css_pkg::css_src_e freq_src,
  input wire css_pkg::css_src_e run_src
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       fb_wr;
  logic       lk_wr;
  logic [3:0] fb_mode_reg;
  logic [3:0] fb_mode_next;
  // shadow of the field bus mode so link writes can be judged
  assign fb_wr = reg_wr && reg_addr == css_pkg::ADDR_FBUS_MODE;
  assign lk_wr = reg_wr && reg_addr == css_pkg::ADDR_LINK_MODE && fb_mode_reg == 4'h0;
  always_comb fb_mode_next = fb_wr ? reg_wdata[3:0] : fb_mode_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fb_mode_reg <= 4'h0;
    else fb_mode_reg <= fb_mode_next;
  end
  // mode writes steer the sources two edges later
  fb_freq_sel_a: assert property (fb_wr && reg_wdata[0] && reg_wdata[3:2] == 2'h0
    |-> ##2 freq_src == css_pkg::CSS_SRC_FIELDBUS) else $error("freq source not field bus");
  fb_run_sel_a: assert property (fb_wr && reg_wdata[1] && reg_wdata[3:2] == 2'h0
    |-> ##2 run_src == css_pkg::CSS_SRC_FIELDBUS) else $error("run source not field bus");
  link_std_a: assert property (lk_wr && reg_wdata[3:0] == 4'h3
    |-> ##2 freq_src == css_pkg::CSS_SRC_STD_LINK && run_src == css_pkg::CSS_SRC_STD_LINK)
    else $error("link mode 3 not standard link");
  link_card_a: assert property (lk_wr && reg_wdata[3:0] == 4'h8
    |-> ##2 freq_src == css_pkg::CSS_SRC_CARD_LINK && run_src == css_pkg::CSS_SRC_CARD_LINK)
    else $error("link mode 8 not option card");
  link_local_a: assert property (lk_wr && reg_wdata[3:0] == 4'h0
    |-> ##2 freq_src == css_pkg::CSS_SRC_LOCAL && run_src == css_pkg::CSS_SRC_LOCAL)
    else $error("link mode 0 not local");
  // compare against the sources seen at the write itself, before any move could land
  reserved_hold_a: assert property (fb_wr && reg_wdata[3:0] > 4'h3
    |-> ##2 freq_src == $past(freq_src, 2) && run_src == $past(run_src, 2)) else $error("reserved mode moved source");
  // captured frames reach the outputs two edges after the strobe
  fb_data_a: assert property (fieldbus_in.valid && freq_src == css_pkg::CSS_SRC_FIELDBUS
    && !reg_wr && !$past(reg_wr) |-> ##2 freq_cmd == $past(fieldbus_in.freq, 2)) else $error("field bus freq lost");
  card_data_a: assert property (card_link_in.valid && run_src == css_pkg::CSS_SRC_CARD_LINK
    && !reg_wr && !$past(reg_wr) |-> ##2 run_cmd == $past(card_link_in.run, 2)) else $error("card run lost");
  // main scenarios reached
  cov_fb: cover property (freq_src == css_pkg::CSS_SRC_FIELDBUS && run_src == css_pkg::CSS_SRC_FIELDBUS);
  cov_rsv: cover property (fb_wr && reg_wdata[3:0] > 4'h3);
  cov_card: cover property (card_link_in.valid && run_src == css_pkg::CSS_SRC_CARD_LINK);
endmodule : css_selector_assertions
bind css_selector css_selector_assertions u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .card_link_in(card_link_in), .fieldbus_in(fieldbus_in),
  .freq_cmd(freq_cmd), .run_cmd(run_cmd), .freq_src(freq_src), .run_src(run_src));
`default_nettype wire

/* tb/css_remote_model.sv */
// remote computer model sending frames on the keypad port, card link and field bus
`timescale 1ns/1ps
`default_nettype none
module css_remote_model (
  // request from the bench
  input  wire logic          clk,
  input  wire logic          go,
  input  wire logic [1:0]    port_sel,
  input  wire logic [17:0]   word,
  // frames toward the device
  output var css_pkg::css_port_s keypad_port,
  output var css_pkg::css_cmd_s  card_link,
  output var css_pkg::css_cmd_s  fieldbus
);
  logic [17:0] data;
  // idle lines carry the inverse so stale data never looks like a frame
  assign data = go ? word : ~word;
  // one-cycle frame strobe on the chosen port; 0 keypad, 1 standard link
  always_ff @(posedge clk) begin
    keypad_port <= {go && !port_sel[1], port_sel[0], data};
    card_link   <= {go && port_sel == 2'h2, data};
    fieldbus    <= {go && port_sel == 2'h3, data};
  end
endmodule : css_remote_model
`default_nettype wire

/* tb/command_source_selector_tb_top.sv */
// self-checking bench for the command source selector
`timescale 1ns/1ps
`default_nettype none
module command_source_selector_tb_top;
  logic               clk;
  logic               resetn;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic [3:0][15:0]   local_freq_in;
  logic               alt_sel_in;
  logic [1:0]         preset_sel_in;
  logic [1:0]         term_run_in;
  logic               go;
  logic [1:0]         port_sel;
  logic [17:0]        word;
  logic               rd_seen;
  logic [31:0]        seed;
  logic [15:0]        pre2;
  logic [31:0]        exp_q[$];
  int                 fail_count;
  int                 check_count;
  css_pkg::css_port_s keypad_port_in;
  css_pkg::css_cmd_s  card_link_in;
  css_pkg::css_cmd_s  fieldbus_in;
  logic [15:0]        freq_cmd;
  logic [1:0]         run_cmd;
  css_pkg::css_src_e  freq_src;
  css_pkg::css_src_e  run_src;

  css_selector u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_freq_in(local_freq_in),
    .alt_sel_in(alt_sel_in), .preset_sel_in(preset_sel_in), .term_run_in(term_run_in),
    .keypad_port_in(keypad_port_in), .card_link_in(card_link_in), .fieldbus_in(fieldbus_in),
    .freq_cmd(freq_cmd), .run_cmd(run_cmd), .freq_src(freq_src), .run_src(run_src));
  css_remote_model u_remote (.clk(clk), .go(go), .port_sel(port_sel), .word(word),
    .keypad_port(keypad_port_in), .card_link(card_link_in), .fieldbus(fieldbus_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected status nibble {run source, freq source}
  function automatic logic [31:0] src_of(input int l, input int f);
    logic [1:0] fs;
    logic [1:0] rs;
    fs = (l inside {1, 3, 7}) ? 2'h1 : (l inside {4, 5, 8}) ? 2'h2 : 2'h0;
    rs = (l inside {2, 3, 5}) ? 2'h1 : (l inside {6, 7, 8}) ? 2'h2 : 2'h0;
    if (f[0]) fs = 2'h3;
    if (f[1]) rs = 2'h3;
    return {28'h0, rs, fs};
  endfunction : src_of
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic send(input logic [1:0] p, input logic [17:0] w);
    @(posedge clk);
    go       <= 1'b1;
    port_sel <= p;
    word     <= w;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : send
  task automatic report_and_stop();
    if (exp_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen === 1'b1) check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {resetn, reg_addr, reg_wdata, reg_wr, reg_rd, alt_sel_in, preset_sel_in, term_run_in} = '0;
    {local_freq_in, go, port_sel, word, pre2, fail_count, check_count} = '0;
    seed = 32'h4E859E95;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 10; a++) rd(8'(a * 4), 32'h0);
    for (int f = 0; f < 4; f++) begin
      for (int l = 0; l < 9; l++) begin
        wr(css_pkg::ADDR_LINK_MODE, 32'(l));
        wr(css_pkg::ADDR_FBUS_MODE, 32'(f));
        rd(css_pkg::ADDR_STATUS, src_of(l, f));
      end
    end
    // reserved settings hold the last sources and raise the flag
    wr(css_pkg::ADDR_FBUS_MODE, 32'h0);
    wr(css_pkg::ADDR_LINK_MODE, 32'h9);
    rd(css_pkg::ADDR_STATUS, 32'h1A);
    wr(css_pkg::ADDR_FBUS_MODE, 32'h3);
    rd(css_pkg::ADDR_STATUS, 32'h0F);
    wr(css_pkg::ADDR_FBUS_MODE, 32'h5);
    rd(css_pkg::ADDR_STATUS, 32'h1F);
    wr(8'h28, 32'hFFFFFFFF);
    rd(8'h28, 32'h0);
    // local frequency from selectors or preset, run from terminals then keypad
    wr(css_pkg::ADDR_FBUS_MODE, 32'h0);
    wr(css_pkg::ADDR_LINK_MODE, 32'h0);
    wr(css_pkg::ADDR_FSEL_ONE, 32'h1);
    wr(css_pkg::ADDR_FSEL_TWO, 32'h3);
    wr(css_pkg::ADDR_RUN_SEL, 32'h1);
    pre2 = seed[31:16];
    wr(css_pkg::ADDR_PRESET_2, {16'h0, pre2});
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      @(posedge clk);
      local_freq_in <= {seed[15:0], seed[31:16], ~seed[15:0], ~seed[31:16]};
      alt_sel_in    <= k[0];
      preset_sel_in <= (k == 2) ? 2'h2 : 2'h0;
      term_run_in   <= seed[1:0];
      rd(css_pkg::ADDR_FREQ_OUT, {14'h0, seed[1:0], k == 2 ? pre2 : k[0] ? seed[15:0] : ~seed[15:0]});
    end
    wr(css_pkg::ADDR_RUN_SEL, 32'h0);
    send(2'h0, {seed[15:0], 2'h2});
    rd(css_pkg::ADDR_FREQ_OUT, {14'h0, 2'h2, pre2});
    // remote sources, each with a frame on a port that is not selected
    for (int s = 1; s < 4; s++) begin
      seed = lfsr(seed);
      wr(css_pkg::ADDR_LINK_MODE, s == 1 ? 32'h3 : 32'h8);
      wr(css_pkg::ADDR_FBUS_MODE, s == 3 ? 32'h3 : 32'h0);
      send(2'(s), seed[17:0]);
      send(s == 1 ? 2'h0 : 2'h1, ~seed[17:0]);
      rd(css_pkg::ADDR_FREQ_OUT, {14'h0, seed[1:0], seed[17:2]});
    end
    // a second reset returns to local sources
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(css_pkg::ADDR_STATUS, 32'h0);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : command_source_selector_tb_top
`default_nettype wire
